// ===== dv/tb_top.sv
/*
  Self-checking bench for the reset-cause block: APB read and write tasks,
  source pulses and a sequence of reset and wake-up cases with expected values.
  Assumes rci_top, rci_pkg and rci_map.svh are compiled and on the include path.
*/
`include "rci_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, clk_en, por_req, bor_req, wdt_timeout, master_clear_pin_b, irq_wake_req, sleep_enter;
  logic [7:0] irq_wake_flags;
  logic [11:0] paddr;
  logic psel, penable, pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready, pslverr, core_hold;
  logic [12:0] pc_load;
  logic [7:0] status_out, port_dir_b, port_dir_c;
  logic [1:0] pwrctl_out;
  logic [5:0] port_dir_a, port_a_latch;
  logic [31:0] rd;
  logic er;
  int n_errors;
  int checked;

  rci_top rci_top_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .por_req(por_req), .bor_req(bor_req),
    .wdt_timeout(wdt_timeout), .master_clear_pin_b(master_clear_pin_b), .irq_wake_req(irq_wake_req),
    .irq_wake_flags(irq_wake_flags), .sleep_enter(sleep_enter), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_hold(core_hold), .pc_load(pc_load), .status_out(status_out),
    .pwrctl_out(pwrctl_out), .port_dir_a(port_dir_a), .port_dir_b(port_dir_b), .port_dir_c(port_dir_c),
    .port_a_latch(port_a_latch));

  // ==================================================
  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000, rd, er);
    cmp(rd, exp, what);
    cmp(er, 1'b0, "pslverr on mapped");
  endtask

  // status, pc and directions from the ports, status also over the bus
  task automatic chk(input logic [7:0] st, input logic [12:0] pc, input logic [7:0] dir);
    // outputs launched by the last edge settle before they are looked at
    @(negedge clk);
    cmp(status_out, st, "status port");
    cmp(pc_load, pc, "pc");
    cmp(port_dir_b, dir, "dir b");
    cmp(port_dir_a, dir[5:0], "dir a");
    cmp(port_dir_c, 8'hFF, "dir c");
    rdc(`RCI_OFF_STATUS, st, "status read");
  endtask

  // 0 master clear, 1 watchdog, 2 irq wake, 3 brown-out, 4 power-on with brown-out
  task automatic fire(input int which);
    int n;
    case (which)
      0: master_clear_pin_b <= 1'b0;
      1: wdt_timeout <= 1'b1;
      2: irq_wake_req <= 1'b1;
      3: bor_req <= 1'b1;
      default: begin
        por_req <= 1'b1;
        bor_req <= 1'b1;
      end
    endcase
    cyc(8);
    master_clear_pin_b <= 1'b1;
    wdt_timeout <= 1'b0;
    irq_wake_req <= 1'b0;
    bor_req <= 1'b0;
    por_req <= 1'b0;
    n = 0;
    // sources pass a two-flop synchroniser, so settle before looking
    do begin
      @(posedge clk);
      n++;
    end while (core_hold !== 1'b0 && n < 50);
    cmp(core_hold, 1'b0, "core_hold released");
    cyc(4);
  endtask

  task automatic sleep;
    sleep_enter <= 1'b1;
    cyc(1);
    sleep_enter <= 1'b0;
    cyc(4);
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==================================================
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(50 * 5000);
    n_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    report_and_stop();
  end

  // ==================================================
  // main sequence
  initial begin
    n_errors = 0;
    checked = 0;
    {rst_b, por_req, bor_req, wdt_timeout, irq_wake_req, sleep_enter} = '0;
    {psel, penable, pwrite, paddr, pwdata, irq_wake_flags} = '0;
    clk_en = 1'b1;
    master_clear_pin_b = 1'b1;
    pstrb = 4'hF;
    cyc(16);
    // values must already stand while reset is held
    // the bus is held in reset too, so only the ports are looked at here
    cmp(status_out, 8'h18, "status in reset");
    cmp(pc_load, 13'h0000, "pc in reset");
    cmp(port_dir_b, 8'hFF, "dir b in reset");
    cmp(port_dir_a, 6'h3F, "dir a in reset");
    cmp(pwrctl_out, 2'b00, "pwrctl in reset");
    cmp(core_hold, 1'b1, "core_hold in reset");
    rst_b <= 1'b1;
    cyc(3);
    apb(1'b0, 12'h030, 32'h0000_0000, rd, er);
    cmp(rd, 32'h0000_0000, "unmapped read");
    cmp(er, 1'b1, "unmapped pslverr");
    wr(`RCI_OFF_STATUS, 32'h0000_00E5);
    chk(8'hFD, 13'h0000, 8'hFF);
    $display("test reset_and_bus done");

    wr(`RCI_OFF_PWRCTL, 32'h0000_0003);
    wr(`RCI_OFF_LATCH_A, 32'h0000_0015);
    wr(`RCI_OFF_DIR_A, 32'h0000_0000);
    wr(`RCI_OFF_DIR_B, 32'h0000_0000);
    wr(`RCI_OFF_DIR_C, 32'h0000_0000);
    fire(0);
    chk(8'h1D, 13'h0000, 8'hFF);
    cmp(port_a_latch, 6'h15, "latch kept on master clear");
    cmp(pwrctl_out, 2'b11, "pwrctl kept on master clear");
    $display("test master_clear_running done");

    wr(`RCI_OFF_PC, 32'h0000_0123);
    wr(`RCI_OFF_DIR_A, 32'h0000_0000);
    wr(`RCI_OFF_DIR_B, 32'h0000_0000);
    sleep();
    cmp(status_out, 8'h15, "status after sleep entry");
    fire(1);
    chk(8'h05, 13'h0124, 8'h00);
    cmp(port_a_latch, 6'h15, "latch kept on wake");
    $display("test watchdog_wake done");

    fire(1);
    chk(8'h0D, 13'h0000, 8'hFF);
    $display("test watchdog_reset done");

    wr(`RCI_OFF_STATUS, 32'h0000_00E5);
    sleep();
    cmp(status_out, 8'hF5, "status asleep");
    fire(0);
    chk(8'h15, 13'h0000, 8'hFF);
    $display("test master_clear_asleep done");

    wr(`RCI_OFF_STATUS, 32'h0000_00A5);
    wr(`RCI_OFF_IRQCTL, 32'h0000_0000);
    wr(`RCI_OFF_PIRQ, 32'h0000_0000);
    wr(`RCI_OFF_PC, 32'h0000_0FFF);
    wr(`RCI_OFF_DIR_A, 32'h0000_0000);
    wr(`RCI_OFF_DIR_B, 32'h0000_0000);
    sleep();
    irq_wake_flags <= 8'h81;
    fire(2);
    chk(8'hB5, 13'h1000, 8'h00);
    rdc(`RCI_OFF_IRQCTL, 32'h0000_0001, "irq control flags");
    rdc(`RCI_OFF_PIRQ, 32'h0000_0001, "peripheral flags");
    wr(`RCI_OFF_IRQCTL, 32'h0000_0080);
    wr(`RCI_OFF_PC, 32'h0000_0100);
    sleep();
    irq_wake_flags <= 8'h02;
    fire(2);
    cmp(pc_load, 13'h0004, "vector on enabled wake");
    $display("test irq_wake done");

    wr(`RCI_OFF_PWRCTL, 32'h0000_0003);
    wr(`RCI_OFF_LATCH_A, 32'h0000_002A);
    fire(3);
    chk(8'h1D, 13'h0000, 8'hFF);
    cmp(pwrctl_out, 2'b10, "pwrctl after brown-out");
    cmp(port_a_latch, 6'h00, "latch after brown-out");
    rdc(`RCI_OFF_CAUSE, 32'h0000_0002, "cause brown-out");
    $display("test brown_out done");

    fire(4);
    cmp(status_out[7:3], 5'b00011, "status after power-on");
    cmp(pwrctl_out[1], 1'b0, "power-on flag");
    cmp(pc_load, 13'h0000, "pc after power-on");
    rdc(`RCI_OFF_CAUSE, 32'h0000_0001, "cause power-on wins");
    $display("test power_on_priority done");
    report_and_stop();
  end
endmodule

// ===== hw/rci_map.svh
/*
  Constants of the reset-cause and initialization block: register offsets on
  the APB, field positions, reset values and init values.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef RCI_MAP_SVH
`define RCI_MAP_SVH
// ==================================================
// register offsets (byte addresses)
`define RCI_OFF_STATUS 12'h000
`define RCI_OFF_PWRCTL 12'h004
`define RCI_OFF_PC 12'h008
`define RCI_OFF_DIR_A 12'h00C
`define RCI_OFF_DIR_B 12'h010
`define RCI_OFF_DIR_C 12'h014
`define RCI_OFF_LATCH_A 12'h018
`define RCI_OFF_IRQCTL 12'h01C
`define RCI_OFF_PIRQ 12'h020
`define RCI_OFF_CAUSE 12'h024
// ==================================================
// field positions
`define RCI_ST_PD 3
`define RCI_ST_TO 4
`define RCI_PC_POR 1
`define RCI_PC_BOR 0
`define RCI_IRQ_GIE 7
// ==================================================
// values
`define RCI_STATUS_POR 8'h18
`define RCI_PC_ZERO 13'h0000
`define RCI_PC_VECTOR 13'h0004
`define RCI_DIR_A_INIT 6'h3F
`define RCI_DIR_INIT 8'hFF
`define RCI_LATCH_A_MASK 6'h3F
`define RCI_PIRQ_MASK 8'h7F
`endif

// ===== hw/rci_pkg.sv
/*
  Types of the reset-cause block: the event enumeration and the state struct.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rci_pkg;
  // ==================================================
  // recorded cause of the last reset or wake-up
  typedef enum logic [2:0] {
    RCI_EV_NONE, RCI_EV_POR, RCI_EV_BOR, RCI_EV_WDT_RST,
    RCI_EV_WDT_WAKE, RCI_EV_MASTER_CLEAR_PIN_RUN, RCI_EV_MASTER_CLEAR_PIN_SLEEP, RCI_EV_IRQ_WAKE
  } rci_event_type;

  typedef struct packed {
    logic [7:0] status;
    logic [1:0] pwrctl;
    logic [12:0] pc;
    logic [5:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [5:0] latch_a;
    logic [7:0] irqctl;
    logic [7:0] pirq;
    logic asleep;
    rci_event_type cause;
    logic [31:0] prdata;
  } rci_state_type;
endpackage

// ===== hw/rci_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous levels.
  Assumes one clock; the first stage feeds only the second.
*/
module rci_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  // ==================================================
  // two stages, reset inactive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule

// ===== hw/rci_top.sv
/*
  Reset-cause recording and special-register initialization, APB slave.
  Assumes reset-source levels arrive asynchronously from the analog and
  timer blocks and are held until the resulting event has been applied.
*/
// Our own choices: the APB interface to the registers and the register offsets.
`include "rci_map.svh"

module rci_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic por_req,
  input wire logic bor_req,
  input wire logic wdt_timeout,
  input wire logic master_clear_pin_b,
  input wire logic irq_wake_req,
  input wire logic [7:0] irq_wake_flags,
  input wire logic sleep_enter,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic core_hold,
  output logic [12:0] pc_load,
  output logic [7:0] status_out,
  output logic [1:0] pwrctl_out,
  output logic [5:0] port_dir_a,
  output logic [7:0] port_dir_b,
  output logic [7:0] port_dir_c,
  output logic [5:0] port_a_latch
);
  rci_pkg::rci_state_type st_reg;
  rci_pkg::rci_state_type st_next;
  logic [5:0] src_sync;
  logic s_por;
  logic s_bor;
  logic s_wdt;
  logic s_master_clear_pin;
  logic s_irq;
  logic hold_reg;
  logic [4:0] src_prev_reg;
  logic [11:0] rd_idx;
  logic wr_acc;
  logic rd_acc;

  // ==================================================
  // synchronise the asynchronous reset sources
  rci_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({por_req, bor_req, wdt_timeout, ~master_clear_pin_b, irq_wake_req, 1'b0}),
    .sync_out(src_sync)
  );
  assign s_por = src_sync[5];
  assign s_bor = src_sync[4];
  assign s_wdt = src_sync[3];
  assign s_master_clear_pin = src_sync[2];
  assign s_irq = src_sync[1];

  // valid offset decode, shared by read and write
  function automatic logic rci_mapped(input logic [11:0] a);
    rci_mapped = (a <= `RCI_OFF_CAUSE) && (a[1:0] == 2'b00);
  endfunction

  // byte-lane merge of an 8-bit register from pstrb lane 0
  function automatic logic [7:0] rci_lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    rci_lane0 = s[0] ? d[7:0] : old;
  endfunction

  assign wr_acc = psel && penable && pwrite && rci_mapped(paddr);
  assign rd_acc = psel && !penable && !pwrite;
  assign rd_idx = paddr;

  // ==================================================
  // next-state: events in priority order, then bus writes
  always_comb begin
    logic [4:0] rise;
    logic [7:0] wr_byte;
    rise = {s_por, s_bor, s_wdt, s_master_clear_pin, s_irq} & ~src_prev_reg;
    // lane-0 merge of the status write, computed once for both slices
    wr_byte = rci_lane0(st_reg.status, pwdata, pstrb);
    st_next = st_reg;
    if (s_por) begin // power-on outranks everything
      st_next.status = `RCI_STATUS_POR;
      st_next.pwrctl[`RCI_PC_POR] = 1'b0;
      st_next.pc = `RCI_PC_ZERO;
      st_next.dir_a = `RCI_DIR_A_INIT;
      st_next.dir_b = `RCI_DIR_INIT;
      st_next.dir_c = `RCI_DIR_INIT;
      st_next.latch_a = '0; // unknown; zero picked to keep sims clean
      st_next.irqctl = '0;
      st_next.pirq = '0;
      st_next.asleep = 1'b0;
      st_next.cause = rci_pkg::RCI_EV_POR;
    end else if (s_bor) begin
      st_next.status = {3'b000, 2'b11, st_reg.status[2:0]};
      st_next.pwrctl[`RCI_PC_BOR] = 1'b0;
      st_next.pc = `RCI_PC_ZERO;
      st_next.dir_a = `RCI_DIR_A_INIT;
      st_next.dir_b = `RCI_DIR_INIT;
      st_next.dir_c = `RCI_DIR_INIT;
      st_next.latch_a = '0;
      st_next.irqctl = '0;
      st_next.pirq = '0;
      st_next.asleep = 1'b0;
      st_next.cause = rci_pkg::RCI_EV_BOR;
    end else if (s_wdt && rise[2]) begin
      if (st_reg.asleep) begin
        // wake-up keeps every register but the flags, the cause and the pc, which steps by one
        st_next.status[`RCI_ST_TO] = 1'b0;
        st_next.status[`RCI_ST_PD] = 1'b0;
        st_next.pc = st_reg.pc + 13'h0001;
        st_next.asleep = 1'b0;
        st_next.cause = rci_pkg::RCI_EV_WDT_WAKE;
      end else begin
        st_next.status = {3'b000, 1'b0, 1'b1, st_reg.status[2:0]};
        st_next.pc = `RCI_PC_ZERO;
        st_next.dir_a = `RCI_DIR_A_INIT;
        st_next.dir_b = `RCI_DIR_INIT;
        st_next.dir_c = `RCI_DIR_INIT;
        st_next.irqctl = {7'h00, st_reg.irqctl[0]};
        st_next.pirq = '0;
        st_next.cause = rci_pkg::RCI_EV_WDT_RST;
      end
    end else if (s_master_clear_pin) begin // level reset, held while pin low
      // a held pin keeps the asleep cause; a fresh press is judged anew
      if (st_reg.asleep || (!rise[1] && st_reg.cause == rci_pkg::RCI_EV_MASTER_CLEAR_PIN_SLEEP)) begin
        st_next.status = {3'b000, 1'b1, 1'b0, st_reg.status[2:0]};
        st_next.cause = rci_pkg::RCI_EV_MASTER_CLEAR_PIN_SLEEP;
      end else begin
        st_next.status = {3'b000, st_reg.status[4:0]};
        st_next.cause = rci_pkg::RCI_EV_MASTER_CLEAR_PIN_RUN;
      end
      st_next.pc = `RCI_PC_ZERO;
      st_next.dir_a = `RCI_DIR_A_INIT;
      st_next.dir_b = `RCI_DIR_INIT;
      st_next.dir_c = `RCI_DIR_INIT;
      st_next.irqctl = {7'h00, st_reg.irqctl[0]};
      st_next.pirq = '0;
      st_next.asleep = 1'b0;
    end else if (s_irq && rise[0] && st_reg.asleep) begin
      st_next.status[`RCI_ST_TO] = 1'b1;
      st_next.status[`RCI_ST_PD] = 1'b0;
      // vector only when the global enable is set
      st_next.pc = st_reg.irqctl[`RCI_IRQ_GIE] ? `RCI_PC_VECTOR : st_reg.pc + 13'h0001;
      st_next.irqctl = st_reg.irqctl | {1'b0, irq_wake_flags[6:0]};
      st_next.pirq = st_reg.pirq | (irq_wake_flags & `RCI_PIRQ_MASK);
      st_next.asleep = 1'b0;
      st_next.cause = rci_pkg::RCI_EV_IRQ_WAKE;
    end else begin
      if (sleep_enter && !st_reg.asleep) begin
        st_next.status[`RCI_ST_PD] = 1'b0;
        st_next.status[`RCI_ST_TO] = 1'b1;
        st_next.asleep = 1'b1;
      end
      if (wr_acc) begin
        case (paddr)
          `RCI_OFF_STATUS: begin
            // software may not touch the two cause flags
            st_next.status = {wr_byte[7:5], st_next.status[4:3], wr_byte[2:0]};
          end
          `RCI_OFF_PWRCTL: begin
            if (pstrb[0]) begin
              st_next.pwrctl = pwdata[1:0]; // software arms the flags
            end
          end
          `RCI_OFF_PC: begin
            if (pstrb[0]) begin
              st_next.pc[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
              st_next.pc[12:8] = pwdata[12:8];
            end
          end
          `RCI_OFF_DIR_A: begin
            if (pstrb[0]) begin
              st_next.dir_a = pwdata[5:0];
            end
          end
          `RCI_OFF_DIR_B: st_next.dir_b = rci_lane0(st_reg.dir_b, pwdata, pstrb);
          `RCI_OFF_DIR_C: st_next.dir_c = rci_lane0(st_reg.dir_c, pwdata, pstrb);
          `RCI_OFF_LATCH_A: begin
            if (pstrb[0]) begin
              st_next.latch_a = pwdata[5:0];
            end
          end
          `RCI_OFF_IRQCTL: st_next.irqctl = rci_lane0(st_reg.irqctl, pwdata, pstrb);
          `RCI_OFF_PIRQ: st_next.pirq = rci_lane0(st_reg.pirq, pwdata, pstrb) & `RCI_PIRQ_MASK;
          default: st_next.cause = st_reg.cause;
        endcase
      end
    end
    // read data captured in the setup cycle; unimplemented bits zero
    if (rd_acc) begin
      case (rd_idx)
        `RCI_OFF_STATUS: st_next.prdata = {24'h000000, st_next.status};
        `RCI_OFF_PWRCTL: st_next.prdata = {30'h0, st_next.pwrctl};
        `RCI_OFF_PC: st_next.prdata = {19'h0, st_next.pc};
        `RCI_OFF_DIR_A: st_next.prdata = {26'h0, st_next.dir_a};
        `RCI_OFF_DIR_B: st_next.prdata = {24'h000000, st_next.dir_b};
        `RCI_OFF_DIR_C: st_next.prdata = {24'h000000, st_next.dir_c};
        `RCI_OFF_LATCH_A: st_next.prdata = {26'h0, st_next.latch_a};
        `RCI_OFF_IRQCTL: st_next.prdata = {24'h000000, st_next.irqctl};
        `RCI_OFF_PIRQ: st_next.prdata = {24'h000000, st_next.pirq & `RCI_PIRQ_MASK};
        `RCI_OFF_CAUSE: st_next.prdata = {29'h0, st_next.cause};
        default: st_next.prdata = 32'h00000000;
      endcase
    end
  end

  // ==================================================
  // state register; asynchronous reset loads the power-on values and also clears the brown-out flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg.status <= `RCI_STATUS_POR;
      st_reg.pwrctl <= 2'h0;
      st_reg.pc <= `RCI_PC_ZERO;
      st_reg.dir_a <= `RCI_DIR_A_INIT;
      st_reg.dir_b <= `RCI_DIR_INIT;
      st_reg.dir_c <= `RCI_DIR_INIT;
      st_reg.latch_a <= 6'h00;
      st_reg.irqctl <= 8'h00;
      st_reg.pirq <= 8'h00;
      st_reg.asleep <= 1'b0;
      st_reg.cause <= rci_pkg::RCI_EV_POR;
      st_reg.prdata <= 32'h00000000;
      src_prev_reg <= 5'h00;
      hold_reg <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
      src_prev_reg <= {s_por, s_bor, s_wdt, s_master_clear_pin, s_irq};
      // core held while any level reset stays asserted, plus one cycle
      hold_reg <= s_por | s_bor | s_master_clear_pin | (s_wdt & ~st_reg.asleep & ~src_prev_reg[2]);
    end
  end

  // ==================================================
  // outputs
  assign prdata = st_reg.prdata;
  assign pready = 1'b1; // single access cycle, no wait states
  assign pslverr = psel && penable && !rci_mapped(paddr);
  assign core_hold = hold_reg;
  assign pc_load = st_reg.pc;
  assign status_out = st_reg.status;
  assign pwrctl_out = st_reg.pwrctl;
  assign port_dir_a = st_reg.dir_a;
  assign port_dir_b = st_reg.dir_b;
  assign port_dir_c = st_reg.dir_c;
  assign port_a_latch = st_reg.latch_a;

  // ==================================================
  // checks
  a_por_flags_legal: assert property (@(posedge clk) disable iff (!rst_b)
    !st_reg.pwrctl[`RCI_PC_POR] |-> (st_reg.status[`RCI_ST_TO] || st_reg.cause != rci_pkg::RCI_EV_POR))
    else $error("power-on flag shown with timeout flag clear");
  a_por_load: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && s_por |=> st_reg.status == `RCI_STATUS_POR && !st_reg.pwrctl[`RCI_PC_POR] && st_reg.pc == 13'h0000)
    else $error("power-on values not loaded");
  a_bor_load: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && s_bor && !s_por |=> !st_reg.pwrctl[`RCI_PC_BOR] && st_reg.status[4:3] == 2'b11 && st_reg.pc == 13'h0000)
    else $error("brown-out values not loaded");
  a_wdt_wake: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && st_reg.asleep && s_wdt && !src_prev_reg[2] && !s_por && !s_bor
    |=> st_reg.status[4:3] == 2'b00 && st_reg.pc == $past(st_reg.pc) + 13'h0001)
    else $error("watchdog wake-up wrong");
  a_wdt_reset: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !st_reg.asleep && s_wdt && !src_prev_reg[2] && !s_por && !s_bor
    |=> st_reg.status[7:3] == 5'b00001 && st_reg.pc == 13'h0000)
    else $error("watchdog reset wrong");
  a_dir_reset: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && (s_por || s_bor || s_master_clear_pin) |=> port_dir_b == 8'hFF && port_dir_a == 6'h3F)
    else $error("port directions not set to input");
  a_irq_vector: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && st_reg.asleep && s_irq && !src_prev_reg[0] && !s_por && !s_bor && !s_wdt && !s_master_clear_pin
    && st_reg.irqctl[7] |=> st_reg.pc == 13'h0004 && st_reg.status[4:3] == 2'b10)
    else $error("interrupt wake-up vector wrong");
  a_por_flag_kept: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !s_por && !wr_acc |=> st_reg.pwrctl[1] == $past(st_reg.pwrctl[1]))
    else $error("power-on flag changed without power-on");
  a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && sleep_enter && !st_reg.asleep && !(s_por || s_bor || s_wdt || s_master_clear_pin || s_irq)
    |=> st_reg.status[4:3] == 2'b10 && st_reg.asleep)
    else $error("sleep entry flags wrong");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && rd_acc && !rci_mapped(paddr) |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_master_clear_pin_run: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && s_master_clear_pin && !s_por && !s_bor && !(s_wdt && !src_prev_reg[2]) && !st_reg.asleep
    && st_reg.cause != rci_pkg::RCI_EV_MASTER_CLEAR_PIN_SLEEP
    |=> st_reg.status[7:3] == {3'b000, $past(st_reg.status[4:3])} && st_reg.pc == 13'h0000)
    else $error("running master clear wrong");
  a_irq_wake: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && st_reg.asleep && s_irq && !src_prev_reg[0] && !s_por && !s_bor && !s_wdt && !s_master_clear_pin
    && !st_reg.irqctl[7] |=> st_reg.pc == $past(st_reg.pc) + 13'h0001 && st_reg.status[4:3] == 2'b10)
    else $error("interrupt wake-up wrong");
  c_wdt_wake: cover property (@(posedge clk) st_reg.cause == rci_pkg::RCI_EV_WDT_WAKE);
  c_irq_wake: cover property (@(posedge clk) st_reg.cause == rci_pkg::RCI_EV_IRQ_WAKE);
  c_master_clear_pin_sleep: cover property (@(posedge clk) st_reg.cause == rci_pkg::RCI_EV_MASTER_CLEAR_PIN_SLEEP);
endmodule
